// ===== hdl/cit_target.v
// serial two-wire target port: framing, addressing, register pointer, write fifo
// Function
// - answer only as target at address 0x6b, never start transfers
// - reads of unmapped locations return 0xff
// - works at 100 kbit/s, 400 kbit/s and 1 Mbit/s bus rates
// - 16-bit registers: low byte at lower address, high byte next
// - data changes only while clock low; one clock pulse per bit
// - data fall with clock high is start, data rise is stop
// - bus busy from start until stop, idle afterwards
// - start held over 2 s without stop resets port, frees lines
// - bytes are 8 bits msb first, each followed by acknowledge
// - target may hold clock low between bytes until ready
// - on ninth pulse sender releases data; receiver pulls it low
// - first byte is 7-bit address plus direction, one means read
// - undefined register address byte is nacked, port stays busy and ignores the bus until the next start or stop
// - multi-byte reads and writes cover every register
`timescale 1ns/1ps
`include "cit_consts.vh"
module cit_target #(
   parameter HANG_CYCLES = `CIT_HANG_CYCLES,
   parameter MAP_LAST    = `CIT_MAP_LAST,
   parameter FIFO_DEPTH  = `CIT_FIFO_DEPTH
)(
   input  wire        core_clk_in,
   input  wire        rst_in,
   input  wire        scl_in,
   input  wire        sda_in,
   output reg         scl_oe_n_out,
   output reg         sda_oe_n_out,
   output reg         scl_out,
   output reg         sda_out,
   output reg  [7:0]  rd_addr_out,
   input  wire [7:0]  rd_data_in,
   output reg  [15:0] wr_word_out,
   output reg         wr_valid_out,
   input  wire        wr_ready_in,
   output reg         busy_out
);
   // =====================================================================
   // states
   localparam ST_IDLE  = 3'h0;
   localparam ST_RX    = 3'h1;
   localparam ST_ACK   = 3'h2;
   localparam ST_TX    = 3'h3;
   localparam ST_MACK  = 3'h4;
   localparam ST_HOLD  = 3'h5;
   localparam ST_SKIP  = 3'h6;
   localparam PH_ADDR  = 2'h0;
   localparam PH_REG   = 2'h1;
   localparam PH_DATA  = 2'h2;

   function in_map;
      input [7:0] a;
      begin
         in_map = (a <= MAP_LAST[7:0]);
      end
   endfunction

   // =====================================================================
   // pin synchronisers and edge detect
   reg  [1:0]  scl_sync_reg;
   reg  [1:0]  sda_sync_reg;
   reg         scl_d_reg;
   reg         sda_d_reg;
   wire        scl_rise;
   wire        scl_fall;
   wire        start_det;
   wire        stop_det;

   always @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         scl_sync_reg <= 2'h3;
         sda_sync_reg <= 2'h3;
         scl_d_reg    <= 1'b1;
         sda_d_reg    <= 1'b1;
      end
      else
      begin
         scl_sync_reg <= {scl_sync_reg[0], scl_in};
         sda_sync_reg <= {sda_sync_reg[0], sda_in};
         scl_d_reg    <= scl_sync_reg[1];
         sda_d_reg    <= sda_sync_reg[1];
      end
   end

   // sampling at 100 mhz gives 50 samples per high at 1 mbit/s, ample margin
   assign scl_rise  = scl_sync_reg[1] & ~scl_d_reg;
   assign scl_fall  = ~scl_sync_reg[1] & scl_d_reg;
   assign start_det = scl_sync_reg[1] & scl_d_reg & sda_d_reg & ~sda_sync_reg[1];
   assign stop_det  = scl_sync_reg[1] & scl_d_reg & ~sda_d_reg & sda_sync_reg[1];

   // =====================================================================
   // write path fifo: two bytes pair into {pointer, data}
   wire [15:0] fifo_out;
   wire        fifo_valid;
   wire        fifo_in_ready;
   reg  [15:0] fifo_in_reg;
   reg         fifo_push_reg;

   cit_fifo #(
      .WIDTH (16),
      .DEPTH (FIFO_DEPTH),
      .AW    (3)
   ) u_fifo (
      .core_clk_in   (core_clk_in),
      .rst_in        (rst_in),
      .in_data_in    (fifo_in_reg),
      .in_valid_in   (fifo_push_reg),
      .in_ready_out  (fifo_in_ready),
      .out_data_out  (fifo_out),
      .out_valid_out (fifo_valid),
      .out_ready_in  (~wr_valid_out)
   );

   // =====================================================================
   // protocol engine
   reg  [2:0]  state_reg;
   reg  [1:0]  phase_reg;
   reg  [3:0]  bit_reg;
   reg  [7:0]  shift_reg;
   reg  [7:0]  ptr_reg;
   reg         nack_reg;
   reg  [31:0] hang_reg;

   always @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         state_reg     <= ST_IDLE;
         phase_reg     <= PH_ADDR;
         bit_reg       <= 4'h0;
         shift_reg     <= 8'h00;
         ptr_reg       <= 8'h00;
         nack_reg      <= 1'b0;
         hang_reg      <= 32'h0;
         sda_oe_n_out  <= 1'b1;
         scl_oe_n_out  <= 1'b1;
         sda_out       <= 1'b0;
         scl_out       <= 1'b0;
         busy_out      <= 1'b0;
         rd_addr_out   <= 8'h00;
         fifo_in_reg   <= 16'h0000;
         fifo_push_reg <= 1'b0;
         wr_word_out   <= 16'h0000;
         wr_valid_out  <= 1'b0;
      end
      else
      begin
         fifo_push_reg <= 1'b0;
         rd_addr_out   <= ptr_reg;
         if (wr_valid_out & wr_ready_in)
         begin
            wr_valid_out <= 1'b0;
         end
         else if (fifo_valid & ~wr_valid_out)
         begin
            wr_word_out  <= fifo_out;
            wr_valid_out <= 1'b1;
         end
         if (busy_out)
         begin
            hang_reg <= hang_reg + 32'h1;
         end
         if (stop_det)
         begin
            state_reg    <= ST_IDLE;
            busy_out     <= 1'b0;
            sda_oe_n_out <= 1'b1;
            scl_oe_n_out <= 1'b1;
            hang_reg     <= 32'h0;
         end
         else if (start_det)
         begin
            // repeated start keeps the pointer for the read that follows
            state_reg    <= ST_RX;
            phase_reg    <= PH_ADDR;
            bit_reg      <= 4'h0;
            busy_out     <= 1'b1;
            sda_oe_n_out <= 1'b1;
            scl_oe_n_out <= 1'b1;
            hang_reg     <= 32'h0;
         end
         else if (busy_out && hang_reg >= HANG_CYCLES - 1)
         begin
            state_reg    <= ST_IDLE;
            busy_out     <= 1'b0;
            sda_oe_n_out <= 1'b1;
            scl_oe_n_out <= 1'b1;
            hang_reg     <= 32'h0;
         end
         else
         begin
            case (state_reg)
               ST_IDLE:
               begin
                  sda_oe_n_out <= 1'b1;
               end
               ST_RX:
               begin
                  if (scl_rise)
                  begin
                     shift_reg <= {shift_reg[6:0], sda_sync_reg[1]};
                     bit_reg   <= bit_reg + 4'h1;
                  end
                  else if (scl_fall && bit_reg == `CIT_BITS_PER_BYTE)
                  begin
                     bit_reg <= 4'h0;
                     nack_reg <= 1'b0;
                     state_reg <= ST_ACK;
                     sda_oe_n_out <= 1'b0;
                     case (phase_reg)
                        PH_ADDR:
                        begin
                           if (shift_reg[7:1] != `CIT_TARGET_ADDR)
                           begin
                              sda_oe_n_out <= 1'b1;
                              state_reg    <= ST_SKIP;
                           end
                           else if (shift_reg[0] == `CIT_DIR_READ)
                           begin
                              phase_reg <= PH_DATA;
                              nack_reg  <= 1'b1;
                           end
                           else
                           begin
                              phase_reg <= PH_REG;
                           end
                        end
                        PH_REG:
                        begin
                           if (!in_map(shift_reg))
                           begin
                              sda_oe_n_out <= 1'b1;
                              state_reg    <= ST_SKIP;
                           end
                           else
                           begin
                              ptr_reg   <= shift_reg;
                              phase_reg <= PH_DATA;
                           end
                        end
                        default:
                        begin
                           if (!fifo_in_ready)
                           begin
                              // nack rather than drop when the sink is backed up
                              sda_oe_n_out <= 1'b1;
                              state_reg    <= ST_SKIP;
                           end
                           else
                           begin
                              fifo_in_reg   <= {ptr_reg, shift_reg};
                              fifo_push_reg <= 1'b1;
                              ptr_reg       <= ptr_reg + 8'h01;
                           end
                        end
                     endcase
                  end
               end
               ST_ACK:
               begin
                  if (scl_fall)
                  begin
                     sda_oe_n_out <= 1'b1;
                     if (nack_reg)
                     begin
                        scl_oe_n_out <= 1'b0;
                        state_reg    <= ST_HOLD;
                     end
                     else
                     begin
                        state_reg <= ST_RX;
                     end
                  end
               end
               ST_HOLD:
               begin
                  // clock held low for one cycle while read data settles
                  scl_oe_n_out <= 1'b1;
                  shift_reg    <= in_map(ptr_reg) ? rd_data_in : `CIT_UNMAPPED_BYTE;
                  sda_oe_n_out <= in_map(ptr_reg) ? rd_data_in[7] : 1'b1;
                  bit_reg      <= 4'h0;
                  state_reg    <= ST_TX;
               end
               ST_TX:
               begin
                  if (scl_fall)
                  begin
                     if (bit_reg == `CIT_BITS_PER_BYTE - 4'h1)
                     begin
                        sda_oe_n_out <= 1'b1;
                        ptr_reg      <= ptr_reg + 8'h01;
                        state_reg    <= ST_MACK;
                     end
                     else
                     begin
                        sda_oe_n_out <= shift_reg[6];
                        shift_reg    <= {shift_reg[6:0], 1'b1};
                     end
                     bit_reg <= bit_reg + 4'h1;
                  end
               end
               ST_MACK:
               begin
                  if (scl_rise)
                  begin
                     nack_reg <= sda_sync_reg[1];
                  end
                  else if (scl_fall)
                  begin
                     state_reg <= nack_reg ? ST_SKIP : ST_HOLD;
                     scl_oe_n_out <= nack_reg;
                  end
               end
               ST_SKIP:
               begin
                  sda_oe_n_out <= 1'b1;
               end
               default:
               begin
                  state_reg <= ST_IDLE;
               end
            endcase
         end
      end
   end
endmodule

// ===== common/cit_consts.vh
// constants for the charger serial target port
`ifndef CIT_CONSTS_VH
`define CIT_CONSTS_VH

`define CIT_TARGET_ADDR      7'h6b
`define CIT_UNMAPPED_BYTE    8'hff
`define CIT_MAP_LAST         8'h3f
`define CIT_DIR_READ         1'b1
`define CIT_BITS_PER_BYTE    4'h8
`define CIT_CLK_HZ           100000000
`define CIT_HANG_TIMEOUT_MS  2000
`define CIT_HANG_CYCLES      ((`CIT_CLK_HZ / 1000) * `CIT_HANG_TIMEOUT_MS)
`define CIT_FIFO_DEPTH       8

`endif

// ===== hdl/cit_fifo.v
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module cit_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 8,
   parameter AW    = 3
)(
   input  wire             core_clk_in,
   input  wire             rst_in,
   input  wire [WIDTH-1:0] in_data_in,
   input  wire             in_valid_in,
   output wire             in_ready_out,
   output wire [WIDTH-1:0] out_data_out,
   output wire             out_valid_out,
   input  wire             out_ready_in
);
   reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
   reg [AW-1:0]    wr_reg;
   reg [AW-1:0]    rd_reg;
   reg [AW:0]      cnt_reg;
   wire            push;
   wire            pop;

   assign in_ready_out  = (cnt_reg != DEPTH[AW:0]);
   assign out_valid_out = (cnt_reg != {(AW+1){1'b0}});
   assign out_data_out  = mem_reg[rd_reg];
   assign push          = in_valid_in & in_ready_out;
   assign pop           = out_valid_out & out_ready_in;

   always @(posedge core_clk_in)
   begin
      if (push)
      begin
         mem_reg[wr_reg] <= in_data_in;
      end
      if (rst_in)
      begin
         wr_reg  <= {AW{1'b0}};
         rd_reg  <= {AW{1'b0}};
         cnt_reg <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
         begin
            wr_reg <= (wr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_reg + 1'b1;
         end
         if (pop)
         begin
            rd_reg <= (rd_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_reg + 1'b1;
         end
         if (push & ~pop)
         begin
            cnt_reg <= cnt_reg + 1'b1;
         end
         else if (pop & ~push)
         begin
            cnt_reg <= cnt_reg - 1'b1;
         end
      end
   end
endmodule

// ===== tb/cit_target_properties.sv
// concurrent checks on the serial target port pins
`timescale 1ns/1ps
module cit_target_properties #(
   parameter HANG_CYCLES = 2000
)(
   input wire        core_clk_in,
   input wire        rst_in,
   input wire        scl_in,
   input wire        sda_in,
   input wire        scl_oe_n_out,
   input wire        sda_oe_n_out,
   input wire [15:0] wr_word_out,
   input wire        wr_valid_out,
   input wire        wr_ready_in,
   input wire        busy_out
);
   // ====================
   // busy stretch length
   logic [31:0] busy_len_reg;
   always @(posedge core_clk_in)
   begin
      if (rst_in || !busy_out)
         busy_len_reg <= 32'h0;
      else
         busy_len_reg <= busy_len_reg + 32'h1;
   end
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (rst_in);
   // ====================
   // assertions
   a_reset_frees_lines: assert property (disable iff (1'b0) rst_in |=> scl_oe_n_out &&
      sda_oe_n_out && !busy_out && !wr_valid_out) else $error("reset left lines or flags");
   a_start_sets_busy: assert property ($fell(sda_in) && scl_in && $past(scl_in) |->
      ##[1:5] busy_out) else $error("start not seen");
   a_stop_clears_busy: assert property ($rose(sda_in) && scl_in && $past(scl_in) |->
      ##[1:5] !busy_out) else $error("stop not seen");
   a_data_moves_low: assert property (busy_out && $past(busy_out) && $changed(sda_oe_n_out)
      |-> !scl_in) else $error("data moved with clock high");
   a_stretch_when_low: assert property ($fell(scl_oe_n_out) |-> !scl_in)
      else $error("stretch began with clock high");
   a_word_held: assert property (wr_valid_out && !wr_ready_in |=> wr_valid_out &&
      $stable(wr_word_out)) else $error("write word dropped");
   a_idle_released: assert property (!busy_out && !$past(busy_out) |-> sda_oe_n_out &&
      scl_oe_n_out) else $error("line driven while idle");
   a_hang_bound: assert property (busy_len_reg <= HANG_CYCLES + 8)
      else $error("hung start not cleared");
endmodule

bind cit_target cit_target_properties #(.HANG_CYCLES(HANG_CYCLES)) u_props (
   .core_clk_in(core_clk_in), .rst_in(rst_in), .scl_in(scl_in), .sda_in(sda_in),
   .scl_oe_n_out(scl_oe_n_out), .sda_oe_n_out(sda_oe_n_out), .wr_word_out(wr_word_out),
   .wr_valid_out(wr_valid_out), .wr_ready_in(wr_ready_in), .busy_out(busy_out));

// ===== tb/cit_ctrl_model.sv
// bus controller model driving the two open-drain lines
`timescale 1ns/1ps
module cit_ctrl_model (
   input  wire  scl_line_in,
   input  wire  sda_line_in,
   output logic scl_c_out,
   output logic sda_c_out
);
   // ====================
   // released lines float to the pull-up
   initial
   begin
      scl_c_out = 1'b1;
      sda_c_out = 1'b1;
   end
   // ====================
   // bit and frame tasks
   task automatic bitx(input logic d, output logic q);
      int w;
      sda_c_out = d;
      #40 scl_c_out = 1'b1;
      w = 0;
      #40;
      // bounded wait, target may hold the clock
      while (scl_line_in !== 1'b1 && w < 400)
      begin
         #10 w++;
      end
      q = sda_line_in;
      #40 scl_c_out = 1'b0;
      #40;
   endtask
   task automatic start();
      sda_c_out = 1'b1;
      #40 scl_c_out = 1'b1;
      #80 sda_c_out = 1'b0;
      #80 scl_c_out = 1'b0;
      #40;
   endtask
   task automatic stop();
      sda_c_out = 1'b0;
      #40 scl_c_out = 1'b1;
      #80 sda_c_out = 1'b1;
      #80;
   endtask
   task automatic wbyte(input logic [7:0] v, output logic ack);
      logic q;
      for (int i = 7; i >= 0; i--)
         bitx(v[i], q);
      bitx(1'b1, q);
      ack = ~q;
   endtask
   task automatic rbyte(input logic last, output logic [7:0] v);
      logic q;
      for (int i = 7; i >= 0; i--)
         bitx(1'b1, v[i]);
      bitx(last, q);
   endtask
endmodule

// ===== tb/cit_target_tb.sv
// self-checking bench for the serial target port
`timescale 1ns/1ps
module cit_target_tb;
   logic        core_clk_in = 1'b0;
   logic        rst_in      = 1'b1;
   logic        wr_ready_in = 1'b0;
   logic        stall       = 1'b1;
   wire         scl_c, sda_c, scl_line, sda_line;
   wire         scl_o, sda_o;
   wire         scl_oe_n_out, sda_oe_n_out, wr_valid_out, busy_out;
   wire  [7:0]  rd_addr_out;
   wire  [7:0]  rd_data_in;
   wire  [15:0] wr_word_out;
   logic [7:0]  mem [0:63];
   logic [15:0] exp_q [$];
   int          error_cnt = 0;
   int          cmp_count = 0;
   int          cycles    = 0;
   int          acks;
   always #5 core_clk_in = ~core_clk_in;
   // open drain: a line goes low where the controller drives it low or the port enables its output value
   assign scl_line = scl_c & (scl_oe_n_out | scl_o);
   assign sda_line = sda_c & (sda_oe_n_out | sda_o);
   // marker on unmapped reads: the port must replace it
   assign rd_data_in = (rd_addr_out > 8'h3f) ? 8'h5a : mem[rd_addr_out[5:0]];
   cit_target #(.HANG_CYCLES(2000)) dut (
      .core_clk_in(core_clk_in), .rst_in(rst_in), .scl_in(scl_line), .sda_in(sda_line),
      .scl_oe_n_out(scl_oe_n_out), .sda_oe_n_out(sda_oe_n_out), .scl_out(scl_o), .sda_out(sda_o),
      .rd_addr_out(rd_addr_out), .rd_data_in(rd_data_in), .wr_word_out(wr_word_out),
      .wr_valid_out(wr_valid_out), .wr_ready_in(wr_ready_in), .busy_out(busy_out));
   cit_ctrl_model m (.scl_line_in(scl_line), .sda_line_in(sda_line),
      .scl_c_out(scl_c), .sda_c_out(sda_c));
   // ====================
   // checking and closing
   task chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task results;
      $display("mismatches=%0d compares=%0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   always @(posedge core_clk_in)
   begin
      cycles++;
      if (cycles == 30000)
         chk(16'h0, 16'h1);
      if (cycles == 30000)
         results();
   end
   // ====================
   // user side: stalls or random acceptance
   always @(negedge core_clk_in)
      wr_ready_in <= stall ? 1'b0 : 1'($urandom);
   always @(posedge core_clk_in)
      if (!rst_in && wr_valid_out === 1'b1 && wr_ready_in)
      begin
         if (exp_q.size() == 0)
            chk(wr_word_out, 16'hdead);
         else
            chk(wr_word_out, exp_q.pop_front());
      end
   // ====================
   // transactions
   task wr(input logic [6:0] a, input logic [7:0] r, input int n);
      logic       k;
      logic [7:0] d;
      m.start();
      m.wbyte({a, 1'b0}, k);
      acks = int'(k);
      if (k)
         m.wbyte(r, k);
      acks += int'(k);
      for (int i = 0; i < n && k; i++)
      begin
         d = 8'($urandom);
         // noted first: the word can leave the port before the ack bit ends
         exp_q.push_back({r + 8'(i), d});
         m.wbyte(d, k);
         if (!k)
            void'(exp_q.pop_back());
         acks += int'(k);
      end
      m.stop();
      repeat (10) @(negedge core_clk_in);
   endtask
   task rd(input logic [7:0] r, input int n);
      logic       k;
      logic [7:0] v;
      logic [7:0] a;
      m.start();
      m.wbyte({7'h6b, 1'b0}, k);
      m.wbyte(r, k);
      m.start();
      m.wbyte({7'h6b, 1'b1}, k);
      chk(16'(k), 16'h1);
      for (int i = 0; i < n; i++)
      begin
         a = r + 8'(i);
         m.rbyte(i == n - 1, v);
         chk(16'(v), (a > 8'h3f) ? 16'h00ff : 16'(mem[a[5:0]]));
      end
      m.stop();
      repeat (10) @(negedge core_clk_in);
   endtask
   initial
   begin
      void'($urandom(20));
      foreach (mem[i])
         mem[i] = 8'($urandom);
      repeat (8) @(negedge core_clk_in);
      rst_in = 1'b0;
      repeat (4) @(negedge core_clk_in);
      stall = 1'b0;
      wr(7'h6b, 8'h10, 2);
      chk(16'(acks), 16'h4);
      wr(7'h6a, 8'h10, 1);
      chk(16'(acks), 16'h0);
      wr(7'h6b, 8'h40, 1);
      chk(16'(acks), 16'h1);
      wr(7'h6b, 8'h3f, 1);
      chk(16'(acks), 16'h3);
      rd(8'h3e, 3);
      rd(8'h00, 2);
      // full buffer must refuse further bytes
      stall = 1'b1;
      wr(7'h6b, 8'h00, 10);
      // two header acks, eight words in the fifo, one held at the output
      chk(16'(acks), 16'hb);
      stall = 1'b0;
      repeat (300) @(negedge core_clk_in);
      chk(16'(exp_q.size()), 16'h0);
      m.start();
      chk(16'(busy_out), 16'h1);
      repeat (2100) @(negedge core_clk_in);
      chk(16'({busy_out, sda_oe_n_out, scl_oe_n_out}), 16'h3);
      m.stop();
      repeat (10) @(negedge core_clk_in);
      chk(16'(busy_out), 16'h0);
      results();
   end
endmodule
